// file: rwa_pkg.sv
package rwa_pkg;

	localparam int RWA_ADDR_W = 12;
	localparam int RWA_IDX_W = 7;
	localparam int RWA_NUM_IDX = 128;

	// Register indices; byte address is four times the index
	localparam logic [6:0] RWA_IDX_RAM_POINTER = 7'h08;
	localparam logic [6:0] RWA_IDX_RAM_ACCESS_CONTROL = 7'h09;
	localparam logic [6:0] RWA_IDX_FIRST_CHANNEL_SELECT = 7'h0b;
	localparam logic [6:0] RWA_IDX_FIFO_LEVEL_THRESHOLD = 7'h0c;
	localparam logic [6:0] RWA_IDX_FIFO_CONFIGURATION = 7'h0d;
	localparam logic [6:0] RWA_IDX_CHANNEL_INCREMENT_RESET = 7'h0e;
	localparam logic [6:0] RWA_IDX_PCM_TIMESLOT_SELECT = 7'h10;
	localparam logic [6:0] RWA_IDX_MISC_EVENT_MASK = 7'h11;
	localparam logic [6:0] RWA_IDX_LINE_EVENT_MASK = 7'h12;
	localparam logic [6:0] RWA_IDX_INTERRUPT_CONTROL = 7'h13;
	localparam logic [6:0] RWA_IDX_PIN_OUTPUT_DATA = 7'h48;
	localparam logic [6:0] RWA_IDX_PIN_DRIVE_ENABLE = 7'h4a;
	localparam logic [6:0] RWA_IDX_PIN_FUNCTION_SELECT = 7'h4c;
	localparam logic [6:0] RWA_IDX_LINE_INDICATOR_CONTROL = 7'h4d;
	localparam logic [6:0] RWA_IDX_SYNTH_CONTROL = 7'h50;
	localparam logic [6:0] RWA_IDX_SYNTH_DIVIDER_FIRST = 7'h51;
	localparam logic [6:0] RWA_IDX_SYNTH_DIVIDER_SECOND = 7'h52;
	localparam logic [6:0] RWA_IDX_SYNTH_DIVIDER_THIRD = 7'h53;
	localparam logic [6:0] RWA_IDX_STATUS = 7'h60;
	localparam logic [6:0] RWA_IDX_FIFO_FILL_LEVEL_BLOCK = 7'h61;

	// Aliasing window and the address bit the decoder drops
	localparam logic [6:0] RWA_UPPER_LO = 7'h48;
	localparam logic [6:0] RWA_UPPER_HI = 7'h5f;
	localparam logic [6:0] RWA_ALIAS_MASK = 7'h40;
	localparam int RWA_ALIAS_BIT = 6;

	localparam logic [7:0] RWA_REG_RESET = 8'h00;
	localparam int RWA_STATUS_BUSY_BIT = 0;

	typedef struct packed {
		logic [6:0] idx;
		logic [7:0] data;
		logic own;
		logic alias_hit;
	} rwa_wr_t;

	typedef struct packed {
		logic [7:0] ram_pointer;
		logic [7:0] ram_access_control;
		logic [7:0] first_channel_select;
		logic [7:0] fifo_level_threshold;
		logic [7:0] fifo_configuration;
		logic [7:0] channel_increment_reset;
		logic [7:0] pcm_timeslot_select;
		logic [7:0] misc_event_mask;
		logic [7:0] line_event_mask;
		logic [7:0] interrupt_control;
		logic [7:0] pin_output_data;
		logic [7:0] pin_drive_enable;
		logic [7:0] pin_function_select;
		logic [7:0] line_indicator_control;
		logic [7:0] synth_control;
		logic [7:0] synth_divider_first;
		logic [7:0] synth_divider_second;
		logic [7:0] synth_divider_third;
	} rwa_regs_t;

	function automatic logic rwa_is_writable(input logic [6:0] i);
		unique case (i)
			RWA_IDX_RAM_POINTER, RWA_IDX_RAM_ACCESS_CONTROL, RWA_IDX_FIRST_CHANNEL_SELECT,
			RWA_IDX_FIFO_LEVEL_THRESHOLD, RWA_IDX_FIFO_CONFIGURATION, RWA_IDX_CHANNEL_INCREMENT_RESET,
			RWA_IDX_PCM_TIMESLOT_SELECT, RWA_IDX_MISC_EVENT_MASK, RWA_IDX_LINE_EVENT_MASK,
			RWA_IDX_INTERRUPT_CONTROL, RWA_IDX_PIN_OUTPUT_DATA, RWA_IDX_PIN_DRIVE_ENABLE,
			RWA_IDX_PIN_FUNCTION_SELECT, RWA_IDX_LINE_INDICATOR_CONTROL, RWA_IDX_SYNTH_CONTROL,
			RWA_IDX_SYNTH_DIVIDER_FIRST, RWA_IDX_SYNTH_DIVIDER_SECOND, RWA_IDX_SYNTH_DIVIDER_THIRD: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

endpackage

// file: rwa_reg_cell.sv
`timescale 1ns/1ps
module rwa_reg_cell
	import rwa_pkg::*;
#(
	parameter logic [7:0] RESET_VALUE = RWA_REG_RESET
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Write port
	input wire logic we,
	input wire logic [7:0] wdata,
	// Stored value
	output logic [7:0] q
);

	always_ff @(posedge clock) begin
		if (rst) begin
			q <= RESET_VALUE;
		end else if (we) begin
			q <= wdata;
		end
	end

endmodule

// file: rwa_register_bank.sv
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// RULE1 - A write to an upper-range register is also stored in its lower counterpart.
// RULE2 - Reads and read-only registers never trigger the duplicate write.
// RULE3 - Upper addresses without an own register update nothing when written.
// RULE4 - Writing pin drive enable touches only that register; no counterpart exists.
// RULE5 - Software writes upper registers once at init, lower counterparts afterwards.
// RULE6 - Pin output data may be written anytime; rewrite ram pointer afterwards if used.
// RULE7 - Writing pin function select also overwrites the fifo level threshold.
// RULE8 - Software reads the real fill level before each fifo transfer.
// RULE9 - Line indicator control is rewritten after init only while no fifo is active.
// RULE10 - Before changing line indicator, write fifo configuration then global soft reset.
// RULE11 - Line indicator control is written only while the busy flag reads zero.
// RULE12 - Fifo configuration is rewritten right after, in the same not-busy phase.
// RULE13 - Fifo configuration is only taken into effect during busy phases.
// RULE14 - Synth control is written at init, timeslot select afterwards.
// RULE15 - No synth control write between timeslot select and slot array accesses.
// RULE16 - Divider registers at init only, then masks and interrupt control.
// RULE17 - The alias address is the written address with bit six ignored.
module rwa_register_bank
	import rwa_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [RWA_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core status inputs
	input wire logic fifo_busy,
	input wire logic [7:0] fifo_fill_level_block,
	input wire logic [7:0] pin_input_data,
	// Register contents towards the core
	output rwa_regs_t regs,
	output logic [7:0] fifo_config_active
);

	// Nets, since each element or bit has its own continuous driver
	wire logic [7:0] q [0:RWA_NUM_IDX-1];
	wire logic [RWA_NUM_IDX-1:0] cell_we;
	logic [6:0] idx;
	logic access;
	logic wr_fire;
	logic rd_fire;
	logic [7:0] wdata8;
	rwa_wr_t wr;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic [7:0] rdata_next;
	logic rd_ok;
	logic [7:0] cfg_active_reg;

	assign idx = paddr[8:2];
	assign wdata8 = pwdata[7:0];
	assign access = psel && penable;
	// Writes land only at the edge where the answer is sampled
	assign wr_fire = access && pready_reg && pwrite;
	assign rd_fire = access && pready_reg && !pwrite;

	// Decode of own target and of the alias target
	always_comb begin
		wr.idx = idx & ~RWA_ALIAS_MASK; // see RULE17
		wr.data = wdata8;
		wr.own = rwa_is_writable(idx);
		// Unused upper addresses and missing counterparts stop the alias
		wr.alias_hit = (idx >= RWA_UPPER_LO) && (idx <= RWA_UPPER_HI) && rwa_is_writable(idx)
			&& rwa_is_writable(idx & ~RWA_ALIAS_MASK); // see RULE1 see RULE3 see RULE4
	end

	genvar gi;
	generate
		for (gi = 0; gi < RWA_NUM_IDX; gi++) begin : g_cell
			if (rwa_is_writable(7'(gi))) begin : g_rw
				// Only writes reach the cells, never reads
				assign cell_we[gi] = wr_fire && ((wr.own && idx == 7'(gi))
					|| (wr.alias_hit && wr.idx == 7'(gi))); // see RULE1 see RULE2 see RULE7
				rwa_reg_cell #(
					.RESET_VALUE(RWA_REG_RESET)
				) u_cell (
					.clock(clock),
					.rst(rst),
					.we(cell_we[gi]),
					.wdata(wr.data),
					.q(q[gi])
				);
			end else begin : g_none
				assign cell_we[gi] = 1'b0;
				assign q[gi] = RWA_REG_RESET;
			end
		end
	endgenerate

	// Read mux; the pin data read shares the output data address
	always_comb begin
		rdata_next = 8'h00;
		rd_ok = 1'b1;
		if (idx == RWA_IDX_STATUS) begin
			rdata_next[RWA_STATUS_BUSY_BIT] = fifo_busy;
		end else if (idx == RWA_IDX_FIFO_FILL_LEVEL_BLOCK) begin
			rdata_next = fifo_fill_level_block;
		end else if (idx == RWA_IDX_PIN_OUTPUT_DATA) begin
			rdata_next = pin_input_data;
		end else if (rwa_is_writable(idx)) begin
			rdata_next = q[idx];
		end else begin
			rd_ok = 1'b0;
		end
	end

	// One wait state keeps the answer path registered
	always_ff @(posedge clock) begin
		if (rst) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= access && !pready_reg;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (access && !pready_reg) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdata_next};
			// Writes to read-only or unused words are refused
			pslverr_reg <= pwrite ? !rwa_is_writable(idx) : !rd_ok;
		end else begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
	end

	// Configuration is sampled only while the fifo engine is busy
	always_ff @(posedge clock) begin
		if (rst) begin
			cfg_active_reg <= RWA_REG_RESET;
		end else if (fifo_busy) begin
			cfg_active_reg <= q[RWA_IDX_FIFO_CONFIGURATION]; // see RULE13
		end
	end

	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign prdata = prdata_reg;
	assign fifo_config_active = cfg_active_reg;

	assign regs.ram_pointer = q[RWA_IDX_RAM_POINTER];
	assign regs.ram_access_control = q[RWA_IDX_RAM_ACCESS_CONTROL];
	assign regs.first_channel_select = q[RWA_IDX_FIRST_CHANNEL_SELECT];
	assign regs.fifo_level_threshold = q[RWA_IDX_FIFO_LEVEL_THRESHOLD];
	assign regs.fifo_configuration = q[RWA_IDX_FIFO_CONFIGURATION];
	assign regs.channel_increment_reset = q[RWA_IDX_CHANNEL_INCREMENT_RESET];
	assign regs.pcm_timeslot_select = q[RWA_IDX_PCM_TIMESLOT_SELECT];
	assign regs.misc_event_mask = q[RWA_IDX_MISC_EVENT_MASK];
	assign regs.line_event_mask = q[RWA_IDX_LINE_EVENT_MASK];
	assign regs.interrupt_control = q[RWA_IDX_INTERRUPT_CONTROL];
	assign regs.pin_output_data = q[RWA_IDX_PIN_OUTPUT_DATA];
	assign regs.pin_drive_enable = q[RWA_IDX_PIN_DRIVE_ENABLE];
	assign regs.pin_function_select = q[RWA_IDX_PIN_FUNCTION_SELECT];
	assign regs.line_indicator_control = q[RWA_IDX_LINE_INDICATOR_CONTROL];
	assign regs.synth_control = q[RWA_IDX_SYNTH_CONTROL];
	assign regs.synth_divider_first = q[RWA_IDX_SYNTH_DIVIDER_FIRST];
	assign regs.synth_divider_second = q[RWA_IDX_SYNTH_DIVIDER_SECOND];
	assign regs.synth_divider_third = q[RWA_IDX_SYNTH_DIVIDER_THIRD];

	chk_alias_ram_pointer: assert property (@(posedge clock) disable iff (rst)
		wr_fire && idx == RWA_IDX_PIN_OUTPUT_DATA |=> regs.ram_pointer == $past(wdata8)
		&& regs.pin_output_data == $past(wdata8)) // see RULE1
		else $error("output data write did not reach ram pointer");

	chk_alias_threshold: assert property (@(posedge clock) disable iff (rst)
		wr_fire && idx == RWA_IDX_PIN_FUNCTION_SELECT |=> regs.fifo_level_threshold == regs.pin_function_select) // see RULE7
		else $error("function select write did not overwrite threshold");

	chk_read_no_write: assert property (@(posedge clock) disable iff (rst)
		rd_fire |=> $stable(regs)) // see RULE2
		else $error("read access changed a register");

	chk_unused_upper: assert property (@(posedge clock) disable iff (rst)
		wr_fire && (idx == 7'h49 || idx == 7'h4b || idx == 7'h4e || idx == 7'h4f) |=> $stable(regs)) // see RULE3
		else $error("unused upper address changed a register");

	chk_drive_only: assert property (@(posedge clock) disable iff (rst)
		wr_fire && idx == RWA_IDX_PIN_DRIVE_ENABLE |=> regs.pin_drive_enable == $past(wdata8)
		&& $stable(regs.ram_access_control) && $stable(regs.first_channel_select)) // see RULE4
		else $error("drive enable write disturbed another register");

	chk_cfg_idle_hold: assert property (@(posedge clock) disable iff (rst)
		!fifo_busy |=> $stable(fifo_config_active)) // see RULE13
		else $error("configuration taken outside a busy phase");

	chk_cfg_busy_take: assert property (@(posedge clock) disable iff (rst)
		fifo_busy ##1 fifo_busy |-> fifo_config_active == $past(regs.fifo_configuration)) // see RULE13
		else $error("configuration not taken during busy phase");

	chk_bit6_ignored: assert property (@(posedge clock) disable iff (rst)
		wr_fire && idx == RWA_IDX_SYNTH_DIVIDER_THIRD |=> regs.interrupt_control == regs.synth_divider_third) // see RULE17
		else $error("alias target not formed by dropping bit six");

	chk_apb_answer: assert property (@(posedge clock) disable iff (rst)
		access && !pready ##1 access |-> pready)
		else $error("access phase not answered in one wait state");

endmodule

// file: rwa_tb.sv
`timescale 1ns/1ps
module testbench
	import rwa_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic fifo_busy = 1'b0;
	logic [RWA_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] fill = 8'h3c;
	logic [7:0] pins = 8'hc3;
	logic [7:0] fifo_config_active;
	rwa_regs_t regs;
	logic [143:0] exp_regs = '0;
	int failures = 0;
	int n_tests = 0;
	// Struct field order, first field in the top byte
	logic [6:0] slot_idx [18] = '{7'h08, 7'h09, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h10, 7'h11, 7'h12,
		7'h13, 7'h48, 7'h4a, 7'h4c, 7'h4d, 7'h50, 7'h51, 7'h52, 7'h53};

	rwa_register_bank u_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fifo_busy(fifo_busy), .fifo_fill_level_block(fill), .pin_input_data(pins), .regs(regs),
		.fifo_config_active(fifo_config_active));

	initial begin
		forever #50 clock = ~clock;
	end

	task automatic chk(input string what, input logic [143:0] seen, input logic [143:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic int slot_of(input logic [6:0] i);
		for (int s = 0; s < 18; s++) begin
			if (slot_idx[s] === i) return s;
		end
		return -1;
	endfunction

	// Waits for pready without assuming the latency; bounded so a dead slave cannot hang
	task automatic apb(input logic w, input logic [6:0] idx, input logic [7:0] d, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {3'h0, idx, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			$display("ERROR pready expected 1 seen timeout");
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_check(input logic [6:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		logic er;
		int s;
		int a;
		s = slot_of(idx);
		a = -1;
		if (s >= 0 && idx >= 7'h48 && idx <= 7'h5f) a = slot_of(idx - 7'h40);
		if (s >= 0) exp_regs[(17-s)*8 +: 8] = d;
		if (a >= 0) exp_regs[(17-a)*8 +: 8] = d;
		apb(1'b1, idx, d, rd, er);
		@(negedge clock);
		chk("regs", regs, exp_regs);
		chk("pslverr", 144'(er), 144'(s < 0));
	endtask

	task automatic t_reset();
		chk("regs reset", regs, '0);
		chk("config active reset", 144'(fifo_config_active), '0);
	endtask

	// Upper pass after lower pass shows the alias; second lower pass shows no reverse alias
	task automatic t_alias();
		for (int i = 8'h08; i <= 8'h1f; i++) wr_check(7'(i), 8'(i) ^ 8'ha5);
		for (int i = 8'h48; i <= 8'h5f; i++) wr_check(7'(i), 8'(i) ^ 8'h3c);
		// Lower pass after the upper pass rewrites the counterparts with new values
		for (int i = 8'h08; i <= 8'h13; i++) wr_check(7'(i), 8'(i) + 8'h30);
	endtask

	task automatic t_busy();
		logic [31:0] rd;
		logic er;
		wr_check(7'h0d, 8'h5c);
		repeat (3) @(posedge clock);
		chk("config idle", 144'(fifo_config_active), '0);
		fifo_busy <= 1'b1;
		apb(1'b0, RWA_IDX_STATUS, 8'h00, rd, er);
		chk("status busy", 144'(rd), 144'(1));
		@(negedge clock);
		chk("config busy", 144'(fifo_config_active), 144'(8'h5c));
		@(posedge clock);
		fifo_busy <= 1'b0;
		wr_check(7'h4d, 8'h11);
		wr_check(7'h0d, 8'h5c);
		repeat (2) @(posedge clock);
		chk("config restore", 144'(fifo_config_active), 144'(8'h5c));
	endtask

	task automatic t_reads();
		logic [31:0] rd;
		logic er;
		logic [143:0] snap;
		snap = regs;
		apb(1'b0, 7'h48, 8'h00, rd, er);
		chk("pin input", 144'(rd), 144'(pins));
		apb(1'b0, RWA_IDX_FIFO_FILL_LEVEL_BLOCK, 8'h00, rd, er);
		chk("fill level", 144'(rd), 144'(fill));
		apb(1'b0, 7'h4c, 8'h00, rd, er);
		apb(1'b0, 7'h4d, 8'h00, rd, er);
		apb(1'b0, 7'h7f, 8'h00, rd, er);
		chk("unmapped read", 144'({er, rd}), 144'({1'b1, 32'h0}));
		@(negedge clock);
		chk("regs after reads", regs, snap);
	endtask

	task automatic wrap_up();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		t_reset();
		t_alias();
		t_busy();
		t_reads();
		wrap_up();
	end

	initial begin
		#500000;
		failures++;
		$display("ERROR run expected finish seen timeout");
		wrap_up();
	end
endmodule
